// ==== common/pcr_pkg.sv ====
// Types of the pad config bank
package pcr_pkg;

    typedef enum logic [1:0] {
        PCR_PULL_NONE   = 2'h0,
        PCR_PULL_DOWN   = 2'h1,
        PCR_PULL_UP     = 2'h2,
        PCR_PULL_REPEAT = 2'h3
    } pcr_pull_t;

    typedef struct packed {
        pcr_pull_t  mode;
        logic       hysteresis_enable;
        logic       input_invert;
        logic       open_drain_enable;
    } pcr_cfg_t;

    typedef struct packed {
        logic       pull_up_en;
        logic       pull_down_en;
        logic       hysteresis_en;
    } pcr_pad_ctl_t;

endpackage : pcr_pkg

// ==== common/pcr_regs.svh ====
// Register offsets, field positions and reset values of the pad config bank
`ifndef PCR_REGS_SVH
`define PCR_REGS_SVH

`define PCR_PIN0_ADDR       32'h40044044
`define PCR_PIN14_ADDR      32'h40044048
`define PCR_MODE_LSB        3
`define PCR_MODE_MSB        4
`define PCR_HYS_BIT         5
`define PCR_INV_BIT         6
`define PCR_RSVD_LSB        7
`define PCR_RSVD_MSB        9
`define PCR_OD_BIT          10
`define PCR_MODE_RESET      2'h2
`define PCR_HYS_RESET       1'h1
`define PCR_INV_RESET       1'h0
`define PCR_RSVD_VALUE      3'h1
`define PCR_OD_RESET        1'h0

`endif

// ==== hdl/pcr_pad_config.sv ====
// Pad configuration register bank for pins 0 and 14 on classic Wishbone
//
// Overview of operation
// [RULE1] A 32-bit config register for pin zero at its fixed address.
// [RULE2] Identical register for pin fourteen at the next word address.
// [RULE3] Pull mode bits 4:3 reset 10; hysteresis bit 5 resets 1.
// [RULE4] Mode 0 none, 1 pull-down, 2 pull-up, 3 repeater drives pad; code sets pull_up_en and pull_down_en, pad not driven.
// [RULE5] Bit 6 set inverts pad level seen by internal logic; reset 0.
// [RULE6] Bit 10 set selects open-drain output, clear push-pull; reset 0.
// [RULE7] Open drain is emulated: pad drives low or releases only.
// [RULE8] Bits 2:0, 31:11 read zero; 9:7 read 001; reserved writes ignored.
`timescale 1ns/1ps
`include "pcr_regs.svh"

module pcr_pad_config (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_sys_rst,
    // Wishbone slave
    input  wire logic                  i_wb_cyc,
    input  wire logic                  i_wb_stb,
    input  wire logic                  i_wb_we,
    input  wire logic [31:0]           i_wb_adr,
    input  wire logic [3:0]            i_wb_sel,
    input  wire logic [31:0]           i_wb_dat,
    output logic      [31:0]           o_wb_dat,
    output logic                       o_wb_ack,
    output logic                       o_wb_err,
    // Pin zero pad
    input  wire logic                  i_pin0_pad_in,
    input  wire logic                  i_pin0_out_data,
    input  wire logic                  i_pin0_out_dir,
    output pcr_pkg::pcr_pad_ctl_t      o_pin0_pad_ctl,
    output logic                       o_pin0_pad_out,
    output logic                       o_pin0_pad_oe,
    output logic                       o_pin0_core_in,
    // Pin fourteen pad
    input  wire logic                  i_pin14_pad_in,
    input  wire logic                  i_pin14_out_data,
    input  wire logic                  i_pin14_out_dir,
    output pcr_pkg::pcr_pad_ctl_t      o_pin14_pad_ctl,
    output logic                       o_pin14_pad_out,
    output logic                       o_pin14_pad_oe,
    output logic                       o_pin14_core_in
);

    // Stored configuration and its next value
    pcr_pkg::pcr_cfg_t port_pin_zero;
    pcr_pkg::pcr_cfg_t port_pin_fourteen;
    pcr_pkg::pcr_cfg_t next_port_pin_zero;
    pcr_pkg::pcr_cfg_t next_port_pin_fourteen;

    // Bus decode
    logic              req;
    logic              hit0;
    logic              hit14;
    logic              hit_any;
    logic              wr0;
    logic              wr14;
    logic              rd0;
    logic              rd14;

    // Read path
    logic [31:0]       next_wb_dat;

    // Exact word match; no aliases of the two registers
    function automatic logic addr_hit(
        input logic [31:0] adr,
        input logic [31:0] base
    );
        return (adr == base);
    endfunction : addr_hit

    // Reset image of one pin register
    function automatic pcr_pkg::pcr_cfg_t cfg_reset();
        pcr_pkg::pcr_cfg_t r;
        r.mode              = pcr_pkg::pcr_pull_t'(`PCR_MODE_RESET); // [RULE3]
        r.hysteresis_enable = `PCR_HYS_RESET;                     // [RULE3]
        r.input_invert      = `PCR_INV_RESET;                     // [RULE5]
        r.open_drain_enable = `PCR_OD_RESET;                      // [RULE6]
        return r;
    endfunction : cfg_reset

    // Register image with fixed reserved bits
    function automatic logic [31:0] pack_cfg(input pcr_pkg::pcr_cfg_t c);
        logic [31:0] w;
        w = 32'h0;                                                   // [RULE8]
        w[`PCR_MODE_MSB:`PCR_MODE_LSB] = c.mode;
        w[`PCR_HYS_BIT] = c.hysteresis_enable;
        w[`PCR_INV_BIT] = c.input_invert;
        w[`PCR_RSVD_MSB:`PCR_RSVD_LSB] = `PCR_RSVD_VALUE;            // [RULE8]
        w[`PCR_OD_BIT] = c.open_drain_enable;
        return w;
    endfunction : pack_cfg

    // Byte-lane write merge; only defined fields are stored
    function automatic pcr_pkg::pcr_cfg_t merge_cfg(
        input pcr_pkg::pcr_cfg_t c,
        input logic [31:0]       d,
        input logic [3:0]        sel
    );
        pcr_pkg::pcr_cfg_t n;
        n = c;
        if (sel[0]) begin
            n.mode = pcr_pkg::pcr_pull_t'(d[`PCR_MODE_MSB:`PCR_MODE_LSB]);
            n.hysteresis_enable = d[`PCR_HYS_BIT];
            n.input_invert = d[`PCR_INV_BIT];
        end
        if (sel[1]) begin
            n.open_drain_enable = d[`PCR_OD_BIT];
        end
        return n;                                                    // [RULE8]
    endfunction : merge_cfg

    // Request taken only while no answer is pending
    assign req     = i_wb_cyc & i_wb_stb & ~o_wb_ack & ~o_wb_err;
    assign hit0    = addr_hit(i_wb_adr, `PCR_PIN0_ADDR);         // [RULE1]
    assign hit14   = addr_hit(i_wb_adr, `PCR_PIN14_ADDR);        // [RULE2]
    assign hit_any = hit0 | hit14;
    assign wr0     = req & i_wb_we & hit0;
    assign wr14    = req & i_wb_we & hit14;
    assign rd0     = req & ~i_wb_we & hit0;
    assign rd14    = req & ~i_wb_we & hit14;

    // Byte-lane merge of a write; reserved bits never stored
    always_comb begin
        next_port_pin_zero     = port_pin_zero;
        next_port_pin_fourteen = port_pin_fourteen;
        if (wr0) begin                                           // [RULE1]
            next_port_pin_zero =
                merge_cfg(port_pin_zero, i_wb_dat, i_wb_sel);
        end
        if (wr14) begin                                          // [RULE2]
            next_port_pin_fourteen =
                merge_cfg(port_pin_fourteen, i_wb_dat, i_wb_sel);
        end
    end

    // Pin zero register
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            port_pin_zero <= cfg_reset();                        // [RULE3]
        end else begin
            port_pin_zero <= next_port_pin_zero;
        end
    end

    // Pin fourteen register, same layout and reset
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            port_pin_fourteen <= cfg_reset();                    // [RULE2]
        end else begin
            port_pin_fourteen <= next_port_pin_fourteen;
        end
    end

    // Image of the addressed register on a read, zero otherwise
    always_comb begin
        next_wb_dat = 32'h0;
        if (rd0) begin
            next_wb_dat = pack_cfg(port_pin_zero);               // [RULE1]
        end else if (rd14) begin
            next_wb_dat = pack_cfg(port_pin_fourteen);           // [RULE2]
        end
    end

    // Ack one cycle after a mapped word is taken
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_wb_ack <= 1'b0;
        end else begin
            o_wb_ack <= req & hit_any;
        end
    end

    // Other addresses refused with err, no state change
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_wb_err <= 1'b0;
        end else begin
            o_wb_err <= req & ~hit_any;
        end
    end

    // Read data stands for the answer cycle only
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_dat <= next_wb_dat;                             // [RULE8]
        end
    end

    // Pad controls of pin zero
    pcr_pad_ctl u_pin0 (
        .i_clk      (i_clk),
        .i_sys_rst  (i_sys_rst),
        .i_cfg      (port_pin_zero),
        .i_pad_in   (i_pin0_pad_in),
        .i_out_data (i_pin0_out_data),
        .i_out_dir  (i_pin0_out_dir),
        .o_pad_ctl  (o_pin0_pad_ctl),
        .o_pad_out  (o_pin0_pad_out),
        .o_pad_oe   (o_pin0_pad_oe),
        .o_core_in  (o_pin0_core_in)
    );

    // Pad controls of pin fourteen
    pcr_pad_ctl u_pin14 (
        .i_clk      (i_clk),
        .i_sys_rst  (i_sys_rst),
        .i_cfg      (port_pin_fourteen),
        .i_pad_in   (i_pin14_pad_in),
        .i_out_data (i_pin14_out_data),
        .i_out_dir  (i_pin14_out_dir),
        .o_pad_ctl  (o_pin14_pad_ctl),
        .o_pad_out  (o_pin14_pad_out),
        .o_pad_oe   (o_pin14_pad_oe),
        .o_core_in  (o_pin14_core_in)
    );

endmodule : pcr_pad_config

// ==== hdl/pcr_pad_ctl.sv ====
// Per-pin pad control: pull decode, input invert, emulated open drain
`timescale 1ns/1ps
`include "pcr_regs.svh"

module pcr_pad_ctl (
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    // Configuration
    input  wire pcr_pkg::pcr_cfg_t i_cfg,
    // Pad side
    input  wire logic              i_pad_in,
    input  wire logic              i_out_data,
    input  wire logic              i_out_dir,
    // Controls to pad and core
    output pcr_pkg::pcr_pad_ctl_t  o_pad_ctl,
    output logic                   o_pad_out,
    output logic                   o_pad_oe,
    output logic                   o_core_in
);

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_pad_ctl.pull_up_en    <= 1'b1;
            o_pad_ctl.pull_down_en  <= 1'b0;
            o_pad_ctl.hysteresis_en <= `PCR_HYS_RESET;
        end else begin
            // Repeater enables both keepers
            unique case (i_cfg.mode)                                  // [RULE4]
                pcr_pkg::PCR_PULL_NONE: begin
                    o_pad_ctl.pull_up_en   <= 1'b0;
                    o_pad_ctl.pull_down_en <= 1'b0;
                end
                pcr_pkg::PCR_PULL_DOWN: begin
                    o_pad_ctl.pull_up_en   <= 1'b0;
                    o_pad_ctl.pull_down_en <= 1'b1;
                end
                pcr_pkg::PCR_PULL_UP: begin
                    o_pad_ctl.pull_up_en   <= 1'b1;
                    o_pad_ctl.pull_down_en <= 1'b0;
                end
                pcr_pkg::PCR_PULL_REPEAT: begin
                    o_pad_ctl.pull_up_en   <= 1'b1;
                    o_pad_ctl.pull_down_en <= 1'b1;
                end
            endcase
            o_pad_ctl.hysteresis_en <= i_cfg.hysteresis_enable;      // [RULE3]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_core_in <= 1'b0;
        end else begin
            o_core_in <= i_pad_in ^ i_cfg.input_invert;              // [RULE5]
        end
    end

    // Emulated open drain: drive low only, release for high
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_pad_out <= 1'b0;
            o_pad_oe  <= 1'b0;
        end else if (i_cfg.open_drain_enable) begin                  // [RULE6]
            o_pad_out <= 1'b0;                                       // [RULE7]
            o_pad_oe  <= i_out_dir & ~i_out_data;                    // [RULE7]
        end else begin
            o_pad_out <= i_out_data;
            o_pad_oe  <= i_out_dir;
        end
    end

endmodule : pcr_pad_ctl

// ==== tb/pcr_pad_config_chk.sv ====
// Port assertions of the pad config bank
`timescale 1ns/1ps
`include "pcr_regs.svh"

module pcr_pad_config_chk (
    // Clock, reset, bus
    input wire logic                  i_clk,
    input wire logic                  i_sys_rst,
    input wire logic                  i_wb_cyc,
    input wire logic                  i_wb_stb,
    input wire logic                  i_wb_we,
    input wire logic [31:0]           i_wb_adr,
    input wire logic [31:0]           o_wb_dat,
    input wire logic                  o_wb_ack,
    input wire logic                  o_wb_err,
    // Pads
    input wire logic                  i_pin0_pad_in,
    input wire logic                  i_pin0_out_data,
    input wire logic                  i_pin0_out_dir,
    input wire pcr_pkg::pcr_pad_ctl_t o_pin0_pad_ctl,
    input wire logic                  o_pin0_pad_out,
    input wire logic                  o_pin0_pad_oe,
    input wire logic                  o_pin0_core_in,
    input wire pcr_pkg::pcr_pad_ctl_t o_pin14_pad_ctl
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    wire logic req = i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err;
    wire logic hit0 = i_wb_adr == `PCR_PIN0_ADDR;
    wire logic hit14 = i_wb_adr == `PCR_PIN14_ADDR;
    wire logic rd0 = o_wb_ack && !i_wb_we && hit0;
    wire logic rd14 = o_wb_ack && !i_wb_we && hit14;
    a_ack_mapped: assert property (
        req && (hit0 || hit14) |=> o_wb_ack && !o_wb_err) else $error("no ack");
    a_err_unmapped: assert property (
        req && !hit0 && !hit14 |=> o_wb_err && !o_wb_ack && o_wb_dat == 32'h0)
        else $error("unmapped access not refused");
    a_ack_pulse: assert property (
        o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
    a_rsvd_read: assert property (
        rd0 || rd14 |-> (o_wb_dat & 32'hfffffb87) == 32'h80)
        else $error("reserved bits wrong");
    a_pull_pin0: assert property (
        rd0 |-> o_pin0_pad_ctl == {o_wb_dat[4:3], o_wb_dat[5]})
        else $error("pin zero pad controls wrong");
    a_pull_pin14: assert property (
        rd14 |-> o_pin14_pad_ctl == {o_wb_dat[4:3], o_wb_dat[5]})
        else $error("pin fourteen pad controls wrong");
    a_core_invert: assert property (
        rd0 |-> o_pin0_core_in == ($past(i_pin0_pad_in) ^ o_wb_dat[6]))
        else $error("core input level wrong");
    a_oe_select: assert property (
        rd0 |-> o_pin0_pad_oe == ($past(i_pin0_out_dir)
            && !(o_wb_dat[10] && $past(i_pin0_out_data))))
        else $error("output enable wrong");
    a_out_select: assert property (
        rd0 |-> o_pin0_pad_out == ($past(i_pin0_out_data) && !o_wb_dat[10]))
        else $error("pad output wrong");
    c_od_read: cover property (rd0 && o_wb_dat[10]);
    c_repeater: cover property (rd14 && o_wb_dat[4:3] == 2'h3);
    c_refused: cover property (o_wb_err);
endmodule : pcr_pad_config_chk

bind pcr_pad_config pcr_pad_config_chk u_chk (.*);

// ==== tb/pcr_pad_model.sv ====
// Pad and board model behind one configured pin
`timescale 1ns/1ps

module pcr_pad_model (
    // Clock
    input  wire logic                  i_clk,
    // Pad controls from the bank
    input  wire pcr_pkg::pcr_pad_ctl_t i_ctl,
    input  wire logic                  i_out,
    input  wire logic                  i_oe,
    // Board side driver
    input  wire logic                  i_ext_en,
    input  wire logic                  i_ext_val,
    // Level at the pad input
    output logic                       o_level
);
    initial o_level = 1'b0;
    always @(posedge i_clk) begin
        if (i_oe)
            o_level <= i_out;
        else if (i_ext_en)
            o_level <= i_ext_val;
        else if (i_ctl.pull_up_en != i_ctl.pull_down_en)
            o_level <= i_ctl.pull_up_en;
        else if (!i_ctl.pull_up_en)
            o_level <= ~o_level; // Floating line keeps moving
    end
endmodule : pcr_pad_model

// ==== tb/tb_top.sv ====
// Random and corner tests of the pad config bank
`timescale 1ns/1ps
`include "pcr_regs.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_top;
    logic i_clk = 0, i_sys_rst = 1, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
    logic [31:0] i_wb_adr = 0, i_wb_dat = 0, o_wb_dat, rd, a, d;
    logic [31:0] lfsr = 32'h0f4a0b69;
    logic [3:0] i_wb_sel = 0, s;
    logic [1:0] odat = 0, dir = 0, xen = 0, xval = 0;
    logic [10:0] sh [2];
    logic o_wb_ack, o_wb_err, er, lv, p;
    logic o_pin0_pad_out, o_pin0_pad_oe, o_pin0_core_in;
    logic o_pin14_pad_out, o_pin14_pad_oe, o_pin14_core_in;
    wire logic i_pin0_pad_in, i_pin14_pad_in;
    wire logic i_pin0_out_data = odat[0], i_pin14_out_data = odat[1];
    wire logic i_pin0_out_dir = dir[0], i_pin14_out_dir = dir[1];
    pcr_pkg::pcr_pad_ctl_t o_pin0_pad_ctl, o_pin14_pad_ctl, ctl;
    int fails = 0, n_tests = 0;

    always #25 i_clk = ~i_clk;
    pcr_pad_config dut (.*);
    pcr_pad_model m0 (.i_clk(i_clk), .i_ctl(o_pin0_pad_ctl),
        .i_out(o_pin0_pad_out), .i_oe(o_pin0_pad_oe), .i_ext_en(xen[0]),
        .i_ext_val(xval[0]), .o_level(i_pin0_pad_in));
    pcr_pad_model m14 (.i_clk(i_clk), .i_ctl(o_pin14_pad_ctl),
        .i_out(o_pin14_pad_out), .i_oe(o_pin14_pad_oe), .i_ext_en(xen[1]),
        .i_ext_val(xval[1]), .o_level(i_pin14_pad_in));

    function automatic logic [31:0] nxt(input logic [31:0] r);
        return {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
    endfunction : nxt
    function automatic logic [31:0] img(input logic [10:0] f);
        return {21'h0, f[10], 3'h1, f[6:3], 3'h0};
    endfunction : img

    task automatic wb(input logic w, input logic [31:0] ad, dt,
                      input logic [3:0] sl);
        i_wb_cyc <= 1;
        i_wb_stb <= 1;
        i_wb_we <= w;
        i_wb_adr <= ad;
        i_wb_dat <= dt;
        i_wb_sel <= sl;
        do begin
            @(posedge i_clk);
        end while (o_wb_ack !== 1'b1 && o_wb_err !== 1'b1);
        rd = o_wb_dat;
        er = o_wb_err;
        i_wb_cyc <= 0;
        i_wb_stb <= 0;
        @(posedge i_clk);
    endtask : wb

    task automatic pin_chk(input logic q);
        logic [2:0] got;
        @(posedge i_clk);
        lv = q ? i_pin14_pad_in : i_pin0_pad_in;
        @(posedge i_clk);
        got = q ? {o_pin14_core_in, o_pin14_pad_oe, o_pin14_pad_out}
                : {o_pin0_core_in, o_pin0_pad_oe, o_pin0_pad_out};
        `CHK(got[2], lv ^ sh[q][6])
        `CHK(got[1], dir[q] & ~(sh[q][10] & odat[q]))
        `CHK(got[0], odat[q] & ~sh[q][10])
    endtask : pin_chk

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    initial begin
        #(50 * 3000);
        fails++;
        tally_and_finish;
    end

    initial begin
        sh[0] = 11'h30;
        sh[1] = 11'h30;
        repeat (6) @(posedge i_clk);
        i_sys_rst <= 0;
        @(posedge i_clk);
        `CHK(o_pin0_pad_ctl, 3'h5)
        wb(0, `PCR_PIN0_ADDR, 0, 0);
        `CHK(rd, 32'hb0)
        wb(0, `PCR_PIN14_ADDR, 0, 0);
        `CHK(rd, 32'hb0)
        $display("reset values done");
        for (int i = 0; i < 40; i++) begin
            lfsr = nxt(lfsr);
            p = i < 8 ? i[2] : lfsr[31];
            a = p ? `PCR_PIN14_ADDR : `PCR_PIN0_ADDR;
            d = {lfsr[31:5], i[1:0], lfsr[2:0]};
            s = i < 8 ? 4'hf : lfsr[11:8];
            wb(1, a, d, s);
            if (s[0]) sh[p][6:3] = d[6:3];
            if (s[1]) sh[p][10] = d[10];
            odat <= lfsr[13:12];
            dir <= lfsr[15:14];
            xen <= lfsr[17:16];
            xval <= lfsr[19:18];
            wb(0, a, 0, 0);
            `CHK(rd, img(sh[p]))
            `CHK(er, 1'b0)
            ctl = p ? o_pin14_pad_ctl : o_pin0_pad_ctl;
            `CHK(ctl, {sh[p][4:3], sh[p][5]})
            pin_chk(p);
        end
        $display("random configs done");
        i_sys_rst <= 1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 0;
        sh[0] = 11'h30;
        sh[1] = 11'h30;
        @(posedge i_clk);
        `CHK(o_pin14_pad_ctl, 3'h5)
        wb(0, `PCR_PIN14_ADDR, 0, 0);
        `CHK(rd, img(sh[1]))
        wb(0, `PCR_PIN0_ADDR, 0, 0);
        `CHK(rd, img(sh[0]))
        $display("mid-run reset done");
        wb(1, `PCR_PIN14_ADDR + 32'h4, 32'hffffffff, 4'hf);
        `CHK(er, 1'b1)
        wb(0, `PCR_PIN14_ADDR, 0, 0);
        `CHK(rd, img(sh[1]))
        $display("unmapped access done");
        tally_and_finish;
    end
endmodule : tb_top
